// File: common/lsd_pkg.sv
// Shared constants and types for the LED sink shift/latch driver core
package lsd_pkg;

  localparam int CHANNELS = 16;
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_SHIFT = 8'h08;
  localparam logic [7:0] OFS_LATCH = 8'h0C;
  localparam logic [7:0] OFS_FAULT_LOW = 8'h10;
  localparam logic [7:0] OFS_FAULT_HIGH = 8'h14;
  localparam logic [7:0] OFS_RESULT = 8'h18;

  // Field positions
  localparam int CTRL_FORCE_BLANK_BIT = 0;
  localparam int STATUS_SHUTDOWN_BIT = 0;
  localparam int STATUS_DETECT_BIT = 1;
  localparam int STATUS_DONE_BIT = 2;

  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] FAULT_RESET = 16'h0000;
  localparam logic [15:0] DATA_RESET = 16'h0000;

  // Response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Mode sequences, first clock in bit 4, fifth clock in bit 0
  localparam logic [4:0] SEQ_ENTRY_A = 5'h02;
  localparam logic [4:0] SEQ_ENTRY_B = 5'h17;
  localparam logic [4:0] SEQ_RESUME_A = 5'h00;
  localparam logic [4:0] SEQ_RESUME_B = 5'h17;

  // Timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int DETECT_MIN_PS = 1000000;
  localparam int DETECT_CYC = (DETECT_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DETECT_CNT_W = 8;

  typedef enum logic {
    LSD_MODE_NORMAL = 1'b0,
    LSD_MODE_DETECT = 1'b1
  } lsd_mode_e;

endpackage

// File: design/lsd_sync.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
module lsd_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  import lsd_pkg::*;

  logic [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// File: design/lsd_mode_seq.sv
// Recognizer of the five-clock mode-change patterns on the two control pins
`timescale 1ns/10ps
module lsd_mode_seq (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sample_en,
  input wire logic mode_ctrl_a,
  input wire logic mode_ctrl_b,
  output logic entry_hit,
  output logic resume_hit
);
  import lsd_pkg::*;

  logic [4:0] hist_a_reg;
  logic [4:0] hist_b_reg;
  logic [4:0] hist_a_next;
  logic [4:0] hist_b_next;

  assign hist_a_next = {hist_a_reg[3:0], mode_ctrl_a};
  assign hist_b_next = {hist_b_reg[3:0], mode_ctrl_b};

  // Sample both pins on every serial clock rise, check last five
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hist_a_reg <= 5'h00;
      hist_b_reg <= 5'h00;
      entry_hit <= 1'b0;
      resume_hit <= 1'b0;
    end else if (sample_en) begin
      hist_a_reg <= hist_a_next;
      hist_b_reg <= hist_b_next;
      entry_hit <= (hist_a_next == SEQ_ENTRY_A) && (hist_b_next == SEQ_ENTRY_B);
      resume_hit <= (hist_a_next == SEQ_RESUME_A) && (hist_b_next == SEQ_RESUME_B);
    end else begin
      entry_hit <= 1'b0;
      resume_hit <= 1'b0;
    end
  end

endmodule

// File: design/lsd_core.sv
// LED sink driver digital core: shift register, storage latch, blanking, detection, AXI4-Lite registers
// Functional notes
// - A 16-bit shift register feeds a separate 16-bit storage latch.
// - Each serial clock rise shifts in one bit; serial out is sixteen bits delayed. A rise in the same cycle as a detection load is dropped.
// - Newest bit drives channel 0, oldest channel 15; one means on.
// - Strobe low: the storage latch holds its contents.
// - Strobe high: the storage latch follows the shift register.
// - Strobe and output enable act on levels, not on clock edges.
// - Enable low: every channel shows its latch bit; a set software force bit keeps every channel off instead.
// - Enable high: every channel is off.
// - Undriven enable reads high, undriven strobe reads low.
// - Enable is active low and is the second mode control input.
// - Strobe is the first mode control input; both carry mode sequences.
// - Mode changes only on the dedicated pattern on the two pins.
// - Detection classifies outputs as short to ground, short to supply, or open; the result keeps no class, any low or high fault reads as zero.
// - Detection results load into the shift register and shift out serially.
// - All-zero latched data shuts down with outputs off; any one wakes it.
// - After power-up the device starts in shutdown.
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
module lsd_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [lsd_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [lsd_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [lsd_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [lsd_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic latch_strobe_mode_a,
  input wire logic latch_strobe_driven,
  input wire logic output_blank_n_mode_b,
  input wire logic output_blank_driven,
  output logic serial_out,
  output logic [lsd_pkg::CHANNELS-1:0] sink_channel,
  output logic shutdown_state,
  output logic detect_mode
);
  import lsd_pkg::*;

  // Pin side
  logic strobe_pin;
  logic blank_n_pin;
  logic [3:0] pins_sync;
  logic sclk_s;
  logic sdin_s;
  logic mode_ctrl_a;
  logic mode_ctrl_b;
  logic sclk_prev_reg;
  logic sclk_rise;
  logic entry_hit;
  logic resume_hit;

  // Core state
  logic [CHANNELS-1:0] shift_reg;
  logic [CHANNELS-1:0] latch_reg;
  logic [CHANNELS-1:0] result_reg;
  lsd_mode_e mode_reg;
  logic [DETECT_CNT_W-1:0] detect_cnt_reg;
  logic detect_done_reg;
  logic detect_load;

  // Registers
  logic [31:0] ctrl_reg;
  logic [CHANNELS-1:0] fault_low_reg;
  logic [CHANNELS-1:0] fault_high_reg;

  // AXI state
  logic aw_have_reg;
  logic w_have_reg;
  logic [AXI_AW-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;

  function automatic logic addr_mapped(input logic [AXI_AW-1:0] a);
    addr_mapped = (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_SHIFT) || (a == OFS_LATCH)
      || (a == OFS_FAULT_LOW) || (a == OFS_FAULT_HIGH) || (a == OFS_RESULT);
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge_strb = res;
  endfunction

  // Strobe and enable act about three cycles after the pin, the price of synchronising them
  // An undriven pin settles to its internal pull level
  assign strobe_pin = latch_strobe_driven ? latch_strobe_mode_a : 1'b0;
  assign blank_n_pin = output_blank_driven ? output_blank_n_mode_b : 1'b1;

  lsd_sync #(
    .W(4),
    .RST_VAL(4'h4)
  ) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({serial_clk, blank_n_pin, strobe_pin, serial_in}),
    .sync_out(pins_sync)
  );

  assign sdin_s = pins_sync[0];
  assign mode_ctrl_a = pins_sync[1];
  assign mode_ctrl_b = pins_sync[2];
  assign sclk_s = pins_sync[3];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_s;
    end
  end

  // Rising edge of the synchronised serial clock, found against its value one system cycle earlier
  assign sclk_rise = sclk_s && !sclk_prev_reg;

  lsd_mode_seq u_mode_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .sample_en(sclk_rise),
    .mode_ctrl_a(mode_ctrl_a),
    .mode_ctrl_b(mode_ctrl_b),
    .entry_hit(entry_hit),
    .resume_hit(resume_hit)
  );

  // Patterns only count in the opposite mode, so repeats are ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= LSD_MODE_NORMAL;
    end else begin
      unique case (mode_reg)
        LSD_MODE_NORMAL: begin
          if (entry_hit) begin
            mode_reg <= LSD_MODE_DETECT;
          end
        end
        LSD_MODE_DETECT: begin
          if (resume_hit) begin
            mode_reg <= LSD_MODE_NORMAL;
          end
        end
      endcase
    end
  end

  // Detection window: enable held low long enough while in detect mode
  // The count saturates, so the host may hold the enable low far past the minimum
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      detect_cnt_reg <= '0;
    end else if (mode_reg != LSD_MODE_DETECT || mode_ctrl_b) begin
      detect_cnt_reg <= '0;
    end else if (detect_cnt_reg < DETECT_CNT_W'(DETECT_CYC)) begin
      detect_cnt_reg <= detect_cnt_reg + 1'b1;
    end
  end

  // Results are handed over when the host returns the enable high
  assign detect_load = (mode_reg == LSD_MODE_DETECT) && mode_ctrl_b
    && (detect_cnt_reg == DETECT_CNT_W'(DETECT_CYC));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_reg <= DATA_RESET;
      detect_done_reg <= 1'b0;
    end else if (detect_load) begin
      // Undriven channels and either fault class, low or high, read as zero
      result_reg <= latch_reg & ~(fault_low_reg | fault_high_reg);
      detect_done_reg <= 1'b1;
    end else if (entry_hit && mode_reg == LSD_MODE_NORMAL) begin
      detect_done_reg <= 1'b0;
    end
  end

  // A detection load outranks a serial clock edge in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_reg <= DATA_RESET;
    end else if (detect_load) begin
      shift_reg <= latch_reg & ~(fault_low_reg | fault_high_reg);
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[CHANNELS-2:0], sdin_s};
    end
  end

  assign serial_out = shift_reg[CHANNELS-1];

  // Level-driven latch, refreshed every cycle while the strobe is high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_reg <= DATA_RESET;
    end else if (mode_ctrl_a) begin
      latch_reg <= shift_reg;
    end else begin
      latch_reg <= latch_reg;
    end
  end

  // Shutdown trails the latch by a cycle; harmless, as an all-zero latch already darkens every channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shutdown_state <= 1'b1;
    end else begin
      shutdown_state <= (latch_reg == DATA_RESET);
    end
  end

  // Blanking pin, shutdown and the software force each win over the latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sink_channel <= DATA_RESET;
    end else if (mode_ctrl_b || shutdown_state || ctrl_reg[CTRL_FORCE_BLANK_BIT]) begin
      sink_channel <= DATA_RESET;
    end else begin
      sink_channel <= latch_reg;
    end
  end

  // Registered copy so the mode port comes straight from a flip-flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      detect_mode <= 1'b0;
    end else begin
      detect_mode <= (mode_reg == LSD_MODE_DETECT);
    end
  end

  // AXI4-Lite write side: address and data taken in either order
  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_reg <= 1'b0;
    end
  end

  // A held address or data word blocks the next one until the write has been carried out
  assign s_axi_awready = !aw_have_reg;
  assign s_axi_wready = !w_have_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
      fault_low_reg <= FAULT_RESET;
      fault_high_reg <= FAULT_RESET;
    end else if (wr_fire) begin
      if (aw_addr_reg == OFS_CTRL) begin
        ctrl_reg <= merge_strb(ctrl_reg, w_data_reg, w_strb_reg) & 32'h0000_0001;
      end
      // Fault bits stand in for the per-channel comparators of the output stage
      if (aw_addr_reg == OFS_FAULT_LOW) begin
        fault_low_reg <= 16'(merge_strb({16'h0000, fault_low_reg}, w_data_reg, w_strb_reg));
      end
      if (aw_addr_reg == OFS_FAULT_HIGH) begin
        fault_high_reg <= 16'(merge_strb({16'h0000, fault_high_reg}, w_data_reg, w_strb_reg));
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addr_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read side: one outstanding read, answer one cycle after address
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        OFS_CTRL: s_axi_rdata <= ctrl_reg;
        OFS_STATUS: s_axi_rdata <= {29'h0, detect_done_reg, detect_mode, shutdown_state};
        OFS_SHIFT: s_axi_rdata <= {16'h0000, shift_reg};
        OFS_LATCH: s_axi_rdata <= {16'h0000, latch_reg};
        OFS_FAULT_LOW: s_axi_rdata <= {16'h0000, fault_low_reg};
        OFS_FAULT_HIGH: s_axi_rdata <= {16'h0000, fault_high_reg};
        OFS_RESULT: s_axi_rdata <= {16'h0000, result_reg};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// File: verif/lsd_core_properties.sv
// Port-level checks of the driver core
`timescale 1ns/10ps
module lsd_core_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic output_blank_n_mode_b,
  input wire logic output_blank_driven,
  input wire logic [15:0] sink_channel,
  input wire logic shutdown_state
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Undriven enable pin reads high through the pull-up
  a_blank_forces_off: assert property ((!output_blank_driven || output_blank_n_mode_b)[*6] |-> sink_channel == 16'h0000)
    else $error("channels on while blanked");
  a_shutdown_dark: assert property (shutdown_state[*3] |-> sink_channel == 16'h0000)
    else $error("channels on during shutdown");
  a_reset_shutdown: assert property (disable iff (1'b0) !aresetn |=> shutdown_state)
    else $error("shutdown not set by reset");
  a_reset_ready: assert property (disable iff (1'b0) $rose(aresetn) |-> s_axi_awready && s_axi_wready && s_axi_arready)
    else $error("ready low after reset");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not retired");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
endmodule

bind lsd_core lsd_core_properties u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .output_blank_n_mode_b, .output_blank_driven, .sink_channel, .shutdown_state);

// File: verif/lsd_host_model.sv
// Host model driving the serial and control pins
`timescale 1ns/10ps
module lsd_host_model (
  input wire logic aclk,
  output logic serial_clk,
  output logic serial_in,
  output logic strobe,
  output logic strobe_drv,
  output logic blank_n,
  output logic blank_drv
);
  initial begin
    serial_clk = 1'b0;
    serial_in = 1'b0;
    strobe = 1'b0;
    strobe_drv = 1'b1;
    blank_n = 1'b1;
    blank_drv = 1'b1;
  end
  // Three cycles a phase keeps the serial clock far below its ceiling
  task automatic send_bit(input logic b);
    serial_in <= b;
    repeat (3) @(posedge aclk);
    serial_clk <= 1'b1;
    repeat (3) @(posedge aclk);
    serial_clk <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  task automatic latch_pulse();
    repeat (3) @(posedge aclk);
    strobe <= 1'b1;
    repeat (6) @(posedge aclk);
    strobe <= 1'b0;
  endtask
  // Enable low on clock two; strobe high on clock four only when entering
  task automatic mode(input logic entry);
    logic [4:0] a;
    a = entry ? 5'h02 : 5'h00;
    for (int i = 4; i >= 0; i--) begin
      strobe <= a[i];
      blank_n <= (i != 3);
      send_bit(1'b0);
    end
    strobe <= 1'b0;
    blank_n <= 1'b1;
  endtask
endmodule

// File: verif/tb_lsd_core.sv
// Self-checking bench for the driver core
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb_lsd_core;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid, bready, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic sclk, sin, strobe, strobe_drv, blank_n, blank_drv, serial_out, shutdown_state, detect_mode;
  logic [15:0] sink_channel;
  int bad_count, n_checks;
  localparam logic [15:0] A = 16'hA5C3;
  localparam logic [15:0] B = 16'h3C0F;

  lsd_core DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .serial_clk(sclk), .serial_in(sin), .latch_strobe_mode_a(strobe),
    .latch_strobe_driven(strobe_drv), .output_blank_n_mode_b(blank_n), .output_blank_driven(blank_drv),
    .serial_out(serial_out), .sink_channel(sink_channel), .shutdown_state(shutdown_state),
    .detect_mode(detect_mode));
  lsd_host_model host (.aclk(aclk), .serial_clk(sclk), .serial_in(sin), .strobe(strobe),
    .strobe_drv(strobe_drv), .blank_n(blank_n), .blank_drv(blank_drv));

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic timeout();
    bad_count++;
    final_report();
  endtask
  // Handshake values are read before this edge's updates land
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 50);
    if (n >= 50) timeout();
    bready <= 1'b0;
    `CHK("write resp", er, bresp)
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed, input string nm);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 50);
    if (n >= 50) timeout();
    rready <= 1'b0;
    `CHK({nm, " resp"}, er, rresp)
    `CHK(nm, ed, rdata)
    @(posedge aclk);
  endtask
  task automatic wait_on(input int sel, input logic [15:0] e, input string nm);
    logic [15:0] v;
    for (int n = 0; n < 40; n++) begin
      @(posedge aclk);
      v = sel == 0 ? sink_channel : {15'h0000, sel == 1 ? shutdown_state : detect_mode};
      if (v === e) break;
    end
    `CHK(nm, e, v)
    if (v !== e) final_report();
  endtask
  // Before each new bit the serial output shows the bit sent sixteen clocks earlier
  task automatic shift16(input logic [15:0] d, input logic [15:0] prev);
    for (int i = 15; i >= 0; i--) begin
      `CHK("serial out", prev[i], serial_out)
      host.send_bit(d[i]);
    end
  endtask

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    bready = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h04, 2'h0, 32'h0000_0001, "status");
    rd(8'h00, 2'h0, 32'h0000_0000, "ctrl");
    rd(8'h1C, 2'h2, 32'h0000_0000, "unmapped");
    wr(8'h1C, 32'h0000_0001, 2'h2);
    $display("test reset done");
    shift16(A, 16'h0000);
    host.latch_pulse();
    host.blank_n <= 1'b0;
    wait_on(0, A, "channels");
    wait_on(1, 16'h0000, "awake");
    host.strobe <= 1'b1;
    host.strobe_drv <= 1'b0;
    shift16(B, A);
    host.strobe <= 1'b0;
    host.strobe_drv <= 1'b1;
    repeat (10) @(posedge aclk);
    `CHK("held channels", A, sink_channel)
    rd(8'h08, 2'h0, {16'h0000, B}, "shift");
    rd(8'h0C, 2'h0, {16'h0000, A}, "latch");
    $display("test shift done");
    host.blank_n <= 1'b1;
    wait_on(0, 16'h0000, "blanked");
    host.blank_n <= 1'b0;
    wait_on(0, A, "enabled");
    host.blank_drv <= 1'b0;
    wait_on(0, 16'h0000, "pulled up");
    host.blank_drv <= 1'b1;
    wait_on(0, A, "redriven");
    wr(8'h00, 32'h0000_0001, 2'h0);
    wait_on(0, 16'h0000, "forced off");
    rd(8'h00, 2'h0, 32'h0000_0001, "ctrl");
    wr(8'h00, 32'h0000_0000, 2'h0);
    wait_on(0, A, "unforced");
    $display("test enable done");
    shift16(16'h0000, B);
    host.latch_pulse();
    wait_on(1, 16'h0001, "shutdown");
    `CHK("dark", 16'h0000, sink_channel)
    $display("test shutdown done");
    host.mode(1'b1);
    wait_on(2, 16'h0001, "detect");
    rd(8'h04, 2'h0, 32'h0000_0003, "status");
    wr(8'h10, 32'h0000_0003, 2'h0);
    wr(8'h14, 32'h0000_0100, 2'h0);
    shift16(16'hFFFF, 16'h0000);
    host.latch_pulse();
    wait_on(1, 16'h0000, "woken");
    host.blank_n <= 1'b0;
    repeat (130) @(posedge aclk);
    host.blank_n <= 1'b1;
    repeat (10) @(posedge aclk);
    rd(8'h18, 2'h0, 32'h0000_FEFC, "result");
    rd(8'h04, 2'h0, 32'h0000_0006, "status");
    shift16(16'h0000, 16'hFEFC);
    host.mode(1'b0);
    wait_on(2, 16'h0000, "normal");
    $display("test detect done");
    final_report();
  end
endmodule
